// ===== common/fepi_pkg.sv
// Package with constants and types for flash and EEPROM protection logic.
package fepi_pkg;

  // Register bus widths.
  localparam int REG_ADDR_W = 3;
  localparam int REG_DATA_W = 8;
  // Global address width of commands and of the configuration field.
  localparam int GADDR_W = 24;

  // Register offsets on the plain register port.
  localparam logic [2:0] REG_FLASH_STATUS = 3'h0;
  localparam logic [2:0] REG_FLASH_CONFIG = 3'h1;
  localparam logic [2:0] REG_ERROR_STATUS = 3'h2;
  localparam logic [2:0] REG_ERROR_CONFIG = 3'h3;
  localparam logic [2:0] REG_FLASH_PROTECT = 3'h4;
  localparam logic [2:0] REG_EEPROM_PROTECT = 3'h5;

  // Field positions in the status and configuration registers.
  localparam int ST_CMD_COMPLETE_BIT = 7;
  localparam int ST_PROT_VIOL_BIT = 4;
  localparam int CFG_CMD_IRQ_EN_BIT = 7;
  localparam int ERR_DOUBLE_BIT = 1;
  localparam int ERR_SINGLE_BIT = 0;

  // Field positions in the flash protection register.
  localparam int FP_OPENER_BIT = 7;
  localparam int FP_HIGH_DIS_BIT = 5;
  localparam int FP_HIGH_SIZE_LSB = 3;
  localparam int FP_LOW_DIS_BIT = 2;
  localparam int FP_LOW_SIZE_LSB = 0;
  // Implemented bits of the flash protection register.
  localparam logic [7:0] FP_MASK = 8'hBF;

  // Field positions in the EEPROM protection register.
  localparam int EE_OPENER_BIT = 7;
  localparam int EE_SIZE_LSB = 0;
  // Implemented bits of the EEPROM protection register.
  localparam logic [7:0] EE_MASK = 8'h87;

  // Values before the configuration field has been loaded: all protected.
  localparam logic [7:0] FP_RESET = 8'h24;
  localparam logic [7:0] EE_RESET = 8'h07;

  // Configuration field layout in flash.
  localparam logic [23:0] CFG_KEY_FIRST = 24'h000400;
  localparam logic [23:0] CFG_KEY_LAST = 24'h000407;
  localparam logic [23:0] CFG_RSVD_FIRST = 24'h000408;
  localparam logic [23:0] CFG_RSVD_LAST = 24'h00040B;
  localparam logic [23:0] CFG_EE_PROT_ADDR = 24'h00040C;
  localparam logic [23:0] CFG_FL_PROT_ADDR = 24'h00040D;
  localparam logic [23:0] CFG_SECURITY_ADDR = 24'h00040E;
  localparam logic [23:0] CFG_NONVOL_ADDR = 24'h00040F;
  localparam logic [7:0] CFG_RSVD_VALUE = 8'hFF;

  // Flash protectable region bounds.
  localparam logic [23:0] FLASH_LOW_BASE = 24'h000000;
  localparam logic [23:0] FLASH_HIGH_END = 24'h007FFF;
  // Start of the higher region for each size code, code 3 down to 0.
  localparam logic [3:0][23:0] HIGH_START =
    {24'h006000, 24'h007000, 24'h007800, 24'h007C00};
  // End of the lower region for each size code, code 3 down to 0.
  localparam logic [3:0][23:0] LOW_END =
    {24'h003FFF, 24'h001FFF, 24'h000FFF, 24'h0007FF};

  // EEPROM range starts at zero; each size step adds 32 bytes.
  localparam logic [23:0] EE_BASE = 24'h000000;
  localparam logic [4:0] EE_STEP_LOW_BITS = 5'h1F;

  // Allowed scenario changes; row is the present scenario, bit the new one.
  localparam logic [7:0][7:0] SCEN_ALLOWED = 64'hFF5A3C18080C0A0F;
  // Scenario with no protection at all.
  localparam logic [2:0] SCEN_NONE = 3'h7;

  // Command codes understood by the decoder.
  typedef enum logic [7:0] {
    FEPI_ERASE_VERIFY_ALL = 8'h01,
    FEPI_ERASE_VERIFY_BLOCK = 8'h02,
    FEPI_ERASE_VERIFY_SECTION = 8'h03,
    FEPI_READ_ONCE = 8'h04,
    FEPI_PROGRAM_FLASH = 8'h06,
    FEPI_PROGRAM_ONCE = 8'h07,
    FEPI_ERASE_ALL = 8'h08,
    FEPI_ERASE_BLOCK = 8'h09,
    FEPI_ERASE_SECTOR = 8'h0A,
    FEPI_UNSECURE = 8'h0B,
    FEPI_VERIFY_KEY = 8'h0C,
    FEPI_USER_MARGIN = 8'h0D,
    FEPI_FACTORY_MARGIN = 8'h0E,
    FEPI_EE_ERASE_VERIFY = 8'h10,
    FEPI_EE_PROGRAM = 8'h11,
    FEPI_EE_ERASE_SECTOR = 8'h12
  } fepi_cmd_code_t;

  // One command: its code and its global target address.
  typedef struct packed {
    logic [7:0] code;
    logic [23:0] addr;
  } fepi_cmd_t;

  // Controller states.
  typedef enum logic [2:0] {
    FEPI_LOAD_EE = 3'b000,
    FEPI_LOAD_FL = 3'b001,
    FEPI_LOAD_LAST = 3'b010,
    FEPI_IDLE = 3'b011,
    FEPI_BUSY = 3'b100,
    FEPI_DONE = 3'b101
  } fepi_state_t;

endpackage

// ===== dv/fepi_far_side.sv
// Far-side model: configuration field in flash and the array sequencer.
`timescale 1ns/100ps
module fepi_far_side (
  input wire logic i_clock,
  input wire logic i_cfg_rd,
  input wire logic [23:0] i_cfg_addr,
  input wire logic [7:0] i_ee_byte,
  input wire logic [7:0] i_fl_byte,
  input wire logic i_go,
  output logic [7:0] o_cfg_data,
  output logic o_done
);
  int wait_cnt = 0; // Cycles left until the array reports completion.
  initial o_cfg_data = 8'hA5;
  initial o_done = 1'b0;
  // Serves option bytes; outside a fetch the data lines keep toggling.
  always @(posedge i_clock) begin
    if (i_cfg_rd) begin
      o_cfg_data <= (i_cfg_addr == 24'h00040C) ? i_ee_byte :
        (i_cfg_addr == 24'h00040D) ? i_fl_byte : 8'hFF;
    end else begin
      o_cfg_data <= ~o_cfg_data;
    end
  end
  // Array answers after a random delay, prompt or slow.
  always @(posedge i_clock) begin
    o_done <= (wait_cnt == 1);
    if (i_go) begin
      wait_cnt <= 1 + $urandom_range(5);
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// ===== dv/fepi_protect_bench.sv
// Self-checking bench for the protection and interrupt block.
`timescale 1ns/100ps
module fepi_protect_bench;
  logic clk = 0, rst = 1, wr = 0, rd = 0, cv = 0, done, es = 0, ed = 0;
  logic msk = 0, rd_d = 0, cr, go, ci, ei, rdy;
  logic [2:0] ad = 0;
  logic [7:0] wd = 0, rdata, cd, eb = 8'h87, fb = 8'hFF;
  logic [23:0] ca;
  fepi_pkg::fepi_cmd_t cmd = '0, acmd;
  logic [7:0] q[$]; // Expected read data, oldest first.
  int err_count = 0, n_tests = 0, gos = 0, cyc = 0, g0;
  // Allowed changes: bit 8*from+to set when legal.
  localparam bit [63:0] ALW = 64'hFF5A3C18080C0A0F;
  logic [7:0] a, b;
  fepi_protect dut_u (.i_clock(clk), .i_rst(rst), .i_reg_addr(ad),
    .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .o_cfg_rd(cr), .o_cfg_addr(ca), .i_cfg_data(cd), .i_cmd_valid(cv),
    .i_cmd(cmd), .o_cmd_ready(rdy), .o_array_go(go), .o_array_cmd(acmd),
    .i_array_done(done), .i_ecc_single(es), .i_ecc_double(ed),
    .i_irq_mask(msk), .o_cmd_irq(ci), .o_err_irq(ei));
  fepi_far_side far_u (.i_clock(clk), .i_cfg_rd(cr), .i_cfg_addr(ca),
    .i_ee_byte(eb), .i_fl_byte(fb), .i_go(go), .o_cfg_data(cd),
    .o_done(done));
  always #10 clk = ~clk;
  // Compares one value and counts it.
  task chk(string n, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      $display("[FAIL] %s exp %h got %h", n, e, s);
      err_count++;
    end
  endtask
  task results();
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Monitor: read data stands the cycle after the strobe.
  always @(posedge clk) begin
    rd_d <= rd;
    if (go === 1'b1) gos++;
    if (rd_d) chk("rdata", rdata, q.pop_front());
    if (++cyc == 40000) begin
      err_count++;
      results();
    end
  end
  task wreg(logic [2:0] a_, logic [7:0] d);
    @(posedge clk);
    ad <= a_; wd <= d; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rreg(logic [2:0] a_, logic [7:0] e);
    @(posedge clk);
    ad <= a_; rd <= 1; q.push_back(e);
    @(posedge clk);
    rd <= 0;
  endtask
  // Reset with given option bytes; loading ends a few cycles later.
  task rst_to(logic [7:0] f, logic [7:0] e);
    // Let a pending read result be compared before reset clears it.
    @(posedge clk);
    fb <= f; eb <= e; rst <= 1;
    repeat (11) @(posedge clk);
    rst <= 0;
    repeat (6) @(posedge clk);
  endtask
  task send(logic [7:0] c, logic [23:0] ad_);
    @(posedge clk);
    cv <= 1; cmd <= {c, ad_};
    @(posedge clk);
    cv <= 0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(posedge clk);
    @(posedge clk);
  endtask
  // One command against a fresh protection setting.
  task prot(logic [7:0] f, logic [7:0] e, logic [7:0] c, int ad_, bit v);
    rst_to(f, e);
    g0 = gos;
    send(c, ad_[23:0]);
    chk("go", gos - g0, {31'd0, !v});
    rreg(3'h0, v ? 8'h90 : 8'h80);
  endtask
  function logic [7:0] sb(int s);
    return {s[2], 1'b0, s[1], 2'b00, s[0], 2'b00};
  endfunction
  initial begin
    void'($urandom(29514));
    for (int f = 0; f < 8; f++) for (int t = 0; t < 8; t++) begin
      a = sb(f) | ($urandom & 8'h5B);
      b = sb(t) | ($urandom & 8'h5B);
      rst_to(a, 8'h87);
      rreg(3'h4, a & 8'hBF);
      wreg(3'h4, b);
      rreg(3'h4, (ALW[8*f+t] ? b : a) & 8'hBF);
    end
    rreg(3'h5, 8'h87);
    for (int s = 0; s < 4; s++) begin
      prot(8'h84 | (s << 3), 8'h87, 8'h06,
           32'h7FFF - (32'h400 << s), 0);
      prot(8'h84 | (s << 3), 8'h87, 8'h06,
           32'h8000 - (32'h400 << s), 1);
      prot(8'hA0 | s, 8'h87, 8'h06, (32'h800 << s) - 1, 1);
      prot(8'hA0 | s, 8'h87, 8'h06, 32'h800 << s, 0);
    end
    for (int d = 0; d < 8; d++) begin
      prot(8'hFF, d, 8'h11, d * 32 + 31, 1);
      prot(8'hFF, d, 8'h11, d * 32 + 32, 0);
    end
    prot(8'h24, 8'h87, 8'h06, 32'h5000, 1);
    wreg(3'h0, 8'h10);
    rreg(3'h0, 8'h80);
    rst_to(8'hFF, 8'h87);
    g0 = gos;
    for (int i = 0; i < 5; i++) send(i < 2 ? 8'h0D + i : 8'h0E + i, 24'h5000);
    chk("codes", gos - g0, 5);
    chk("acmd", acmd, {8'h12, 24'h5000});
    wreg(3'h1, 8'h80);
    @(posedge clk);
    chk("cirq", ci, 1);
    msk <= 1;
    @(posedge clk);
    chk("cmask", ci, 0);
    msk <= 0;
    wreg(3'h3, 8'h03);
    es <= 1;
    @(posedge clk);
    es <= 0;
    @(posedge clk);
    chk("eirq", ei, 1);
    rreg(3'h2, 8'h01);
    wreg(3'h2, 8'h01);
    ed <= 1;
    @(posedge clk);
    ed <= 0;
    rreg(3'h2, 8'h02);
    wreg(3'h3, 8'h00);
    @(posedge clk);
    chk("eoff", ei, 0);
    repeat (3) @(posedge clk);
    results();
  end
endmodule

// ===== hw/fepi_protect.sv
// Flash and EEPROM protection, command gating and interrupt requests.
//
// Notes on behaviour
// - interrupts on command completion and ECC faults.
// - command irq is complete flag and enable.
// - error irq from either enabled ECC fault flag.
// - lower, higher and middle flash regions protectable.
// - flash protection loaded from byte 0x040D.
// - opener selects protect-range or unprotect-range polarity.
// - disallowed scenario writes leave register unchanged.
// - only listed scenario transitions are accepted.
// - protection register reads return active scenario.
// - high size field selects top range.
// - EEPROM opener and size loaded from 0x040C.
// - EEPROM range is 32 bytes per step.
// - configuration field layout of key and option bytes.
// - software may change protection after reset.
// - decoder accepts margin and EEPROM commands.
// - complete flag returns to one after command.
`timescale 1ns/100ps
module fepi_protect (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_cfg_rd,
  output logic [23:0] o_cfg_addr,
  input wire logic [7:0] i_cfg_data,
  input wire logic i_cmd_valid,
  input wire fepi_pkg::fepi_cmd_t i_cmd,
  output logic o_cmd_ready,
  output logic o_array_go,
  output fepi_pkg::fepi_cmd_t o_array_cmd,
  input wire logic i_array_done,
  input wire logic i_ecc_single,
  input wire logic i_ecc_double,
  input wire logic i_irq_mask,
  output logic o_cmd_irq,
  output logic o_err_irq
);

  // Controller state.
  fepi_pkg::fepi_state_t state_reg;
  // Status flags and enables.
  logic cmd_complete_flag;
  logic protection_violation_flag;
  logic cmd_complete_irq_en;
  logic ecc_double_fault_flag;
  logic ecc_single_fault_flag;
  logic ecc_double_fault_irq_en;
  logic ecc_single_fault_irq_en;
  // Protection registers.
  logic [7:0] flash_protect_reg;
  logic [7:0] eeprom_protect_reg;
  // Registered outputs.
  logic [7:0] rdata_reg;
  logic [23:0] cfg_addr_reg;
  logic array_go_reg;
  fepi_pkg::fepi_cmd_t array_cmd_reg;

  // Decoded protection fields.
  logic flash_protect_opener;
  logic high_range_disable;
  logic low_range_disable;
  logic [1:0] high_range_size;
  logic [1:0] low_range_size;
  logic eeprom_protect_opener;
  logic [2:0] eeprom_protect_size;
  logic [2:0] scen_now;
  logic [2:0] scen_new;
  // Derived control terms.
  logic loaded;
  logic launch;
  logic cmd_known;
  logic cmd_viol;
  logic fp_wr;
  logic fp_ok;
  logic ee_wr;
  logic hit_high;
  logic hit_low;
  logic hit_ee;
  logic flash_addr_prot;
  logic ee_addr_prot;
  logic [23:0] high_first;
  logic [23:0] low_last;
  logic [23:0] ee_last;

  // Field split of the protection registers.
  assign flash_protect_opener = flash_protect_reg[fepi_pkg::FP_OPENER_BIT];
  assign high_range_disable = flash_protect_reg[fepi_pkg::FP_HIGH_DIS_BIT];
  assign low_range_disable = flash_protect_reg[fepi_pkg::FP_LOW_DIS_BIT];
  assign high_range_size =
    flash_protect_reg[fepi_pkg::FP_HIGH_SIZE_LSB +: 2];
  assign low_range_size = flash_protect_reg[fepi_pkg::FP_LOW_SIZE_LSB +: 2];
  assign eeprom_protect_opener = eeprom_protect_reg[fepi_pkg::EE_OPENER_BIT];
  assign eeprom_protect_size = eeprom_protect_reg[fepi_pkg::EE_SIZE_LSB +: 3];

  // Scenario number is opener, high disable and low disable as three bits.
  assign scen_now =
    {flash_protect_opener, high_range_disable, low_range_disable};
  assign scen_new = {i_reg_wdata[fepi_pkg::FP_OPENER_BIT],
                     i_reg_wdata[fepi_pkg::FP_HIGH_DIS_BIT],
                     i_reg_wdata[fepi_pkg::FP_LOW_DIS_BIT]};
  assign fp_ok = fepi_pkg::SCEN_ALLOWED[scen_now][scen_new];

  // Protection registers may change only once the configuration bytes are in.
  assign loaded = (state_reg == fepi_pkg::FEPI_IDLE) ||
                  (state_reg == fepi_pkg::FEPI_BUSY) ||
                  (state_reg == fepi_pkg::FEPI_DONE);
  assign fp_wr = loaded && i_reg_wr &&
                 (i_reg_addr == fepi_pkg::REG_FLASH_PROTECT);
  assign ee_wr = loaded && i_reg_wr &&
                 (i_reg_addr == fepi_pkg::REG_EEPROM_PROTECT);

  // Region bounds from the size fields.
  assign high_first = fepi_pkg::HIGH_START[high_range_size];
  assign low_last = fepi_pkg::LOW_END[low_range_size];
  assign ee_last = {16'h0000, eeprom_protect_size,
                    fepi_pkg::EE_STEP_LOW_BITS};

  // Higher region: from the size-selected start up to the top.
  fepi_range_check #(
    .WIDTH(24)
  ) u_high (
    .i_addr(i_cmd.addr),
    .i_first(high_first),
    .i_last(fepi_pkg::FLASH_HIGH_END),
    .o_hit(hit_high)
  );

  // Lower region: from zero up to the size-selected end.
  fepi_range_check #(
    .WIDTH(24)
  ) u_low (
    .i_addr(i_cmd.addr),
    .i_first(fepi_pkg::FLASH_LOW_BASE),
    .i_last(low_last),
    .o_hit(hit_low)
  );

  // EEPROM region from address zero.
  fepi_range_check #(
    .WIDTH(24)
  ) u_ee (
    .i_addr(i_cmd.addr),
    .i_first(fepi_pkg::EE_BASE),
    .i_last(ee_last),
    .o_hit(hit_ee)
  );

  // With the opener set the selected ranges are protected; with it clear
  // everything outside the selected ranges is, the middle region included.
  always_comb begin
    logic sel;
    sel = (hit_high && !high_range_disable) ||
          (hit_low && !low_range_disable);
    flash_addr_prot = flash_protect_opener ? sel : !sel;
    ee_addr_prot = !eeprom_protect_opener && hit_ee;
  end

  // Decoder: which codes are known and which hit protected memory.
  always_comb begin
    cmd_known = 1'b1;
    cmd_viol = 1'b0;
    case (i_cmd.code)
      fepi_pkg::FEPI_PROGRAM_FLASH,
      fepi_pkg::FEPI_ERASE_SECTOR: begin
        cmd_viol = flash_addr_prot;
      end
      fepi_pkg::FEPI_ERASE_BLOCK: begin
        cmd_viol = (scen_now != fepi_pkg::SCEN_NONE);
      end
      fepi_pkg::FEPI_ERASE_ALL,
      fepi_pkg::FEPI_UNSECURE: begin
        cmd_viol = (scen_now != fepi_pkg::SCEN_NONE) ||
                   !eeprom_protect_opener;
      end
      fepi_pkg::FEPI_EE_PROGRAM,
      fepi_pkg::FEPI_EE_ERASE_SECTOR: begin
        cmd_viol = ee_addr_prot;
      end
      fepi_pkg::FEPI_ERASE_VERIFY_ALL,
      fepi_pkg::FEPI_ERASE_VERIFY_BLOCK,
      fepi_pkg::FEPI_ERASE_VERIFY_SECTION,
      fepi_pkg::FEPI_READ_ONCE,
      fepi_pkg::FEPI_PROGRAM_ONCE,
      fepi_pkg::FEPI_VERIFY_KEY,
      fepi_pkg::FEPI_USER_MARGIN,
      fepi_pkg::FEPI_FACTORY_MARGIN,
      fepi_pkg::FEPI_EE_ERASE_VERIFY: begin
        cmd_viol = 1'b0;
      end
      default: begin
        cmd_known = 1'b0;
      end
    endcase
  end

  // A command is taken only when idle with the previous one complete.
  assign o_cmd_ready = (state_reg == fepi_pkg::FEPI_IDLE);
  assign launch = i_cmd_valid && o_cmd_ready;

  // Sequencer: configuration load after reset, then command handling.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= fepi_pkg::FEPI_LOAD_EE;
    end else begin
      case (state_reg)
        fepi_pkg::FEPI_LOAD_EE: state_reg <= fepi_pkg::FEPI_LOAD_FL;
        fepi_pkg::FEPI_LOAD_FL: state_reg <= fepi_pkg::FEPI_LOAD_LAST;
        fepi_pkg::FEPI_LOAD_LAST: state_reg <= fepi_pkg::FEPI_IDLE;
        fepi_pkg::FEPI_IDLE: begin
          if (launch) begin
            // Blocked or unknown commands skip the array.
            state_reg <= (cmd_viol || !cmd_known) ? fepi_pkg::FEPI_DONE :
                         fepi_pkg::FEPI_BUSY;
          end
        end
        fepi_pkg::FEPI_BUSY: begin
          if (i_array_done) begin
            state_reg <= fepi_pkg::FEPI_DONE;
          end
        end
        fepi_pkg::FEPI_DONE: state_reg <= fepi_pkg::FEPI_IDLE;
        default: state_reg <= fepi_pkg::FEPI_LOAD_EE;
      endcase
    end
  end

  // Configuration field reads: EEPROM byte first, then flash byte.
  assign o_cfg_rd = (state_reg == fepi_pkg::FEPI_LOAD_EE) ||
                    (state_reg == fepi_pkg::FEPI_LOAD_FL);
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cfg_addr_reg <= fepi_pkg::CFG_EE_PROT_ADDR;
    end else if (state_reg == fepi_pkg::FEPI_LOAD_EE) begin
      cfg_addr_reg <= fepi_pkg::CFG_FL_PROT_ADDR;
    end
  end
  assign o_cfg_addr = cfg_addr_reg;

  // Flash protection: loaded at reset, later only allowed changes.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      flash_protect_reg <= fepi_pkg::FP_RESET;
    end else if (state_reg == fepi_pkg::FEPI_LOAD_LAST) begin
      flash_protect_reg <= i_cfg_data & fepi_pkg::FP_MASK;
    end else if (fp_wr && fp_ok) begin
      flash_protect_reg <= i_reg_wdata & fepi_pkg::FP_MASK;
    end
  end

  // EEPROM protection: loaded at reset, later it may only grow.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      eeprom_protect_reg <= fepi_pkg::EE_RESET;
    end else if (state_reg == fepi_pkg::FEPI_LOAD_FL) begin
      eeprom_protect_reg <= i_cfg_data & fepi_pkg::EE_MASK;
    end else if (ee_wr &&
                 (i_reg_wdata[fepi_pkg::EE_OPENER_BIT] <=
                  eeprom_protect_opener) &&
                 (i_reg_wdata[fepi_pkg::EE_SIZE_LSB +: 3] >=
                  eeprom_protect_size)) begin
      eeprom_protect_reg <= i_reg_wdata & fepi_pkg::EE_MASK;
    end
  end

  // Complete flag: cleared by a launch, set again when it finishes.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cmd_complete_flag <= 1'b0;
    end else if ((state_reg == fepi_pkg::FEPI_DONE) ||
                 (state_reg == fepi_pkg::FEPI_LOAD_LAST)) begin
      cmd_complete_flag <= 1'b1;
    end else if (launch) begin
      cmd_complete_flag <= 1'b0;
    end
  end

  // Violation flag: set on a blocked launch, write one to clear.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      protection_violation_flag <= 1'b0;
    end else if (launch && cmd_viol) begin
      protection_violation_flag <= 1'b1;
    end else if (i_reg_wr && (i_reg_addr == fepi_pkg::REG_FLASH_STATUS) &&
                 i_reg_wdata[fepi_pkg::ST_PROT_VIOL_BIT]) begin
      protection_violation_flag <= 1'b0;
    end
  end

  // ECC fault flags: events win over a write-one clear.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ecc_double_fault_flag <= 1'b0;
      ecc_single_fault_flag <= 1'b0;
    end else begin
      if (i_ecc_double) begin
        ecc_double_fault_flag <= 1'b1;
      end else if (i_reg_wr &&
                   (i_reg_addr == fepi_pkg::REG_ERROR_STATUS) &&
                   i_reg_wdata[fepi_pkg::ERR_DOUBLE_BIT]) begin
        ecc_double_fault_flag <= 1'b0;
      end
      if (i_ecc_single) begin
        ecc_single_fault_flag <= 1'b1;
      end else if (i_reg_wr &&
                   (i_reg_addr == fepi_pkg::REG_ERROR_STATUS) &&
                   i_reg_wdata[fepi_pkg::ERR_SINGLE_BIT]) begin
        ecc_single_fault_flag <= 1'b0;
      end
    end
  end

  // Interrupt enable bits.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cmd_complete_irq_en <= 1'b0;
      ecc_double_fault_irq_en <= 1'b0;
      ecc_single_fault_irq_en <= 1'b0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == fepi_pkg::REG_FLASH_CONFIG) begin
        cmd_complete_irq_en <= i_reg_wdata[fepi_pkg::CFG_CMD_IRQ_EN_BIT];
      end
      if (i_reg_addr == fepi_pkg::REG_ERROR_CONFIG) begin
        ecc_double_fault_irq_en <= i_reg_wdata[fepi_pkg::ERR_DOUBLE_BIT];
        ecc_single_fault_irq_en <= i_reg_wdata[fepi_pkg::ERR_SINGLE_BIT];
      end
    end
  end

  // Array request: one-cycle go pulse with the command held after it.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      array_go_reg <= 1'b0;
      array_cmd_reg <= '0;
    end else begin
      array_go_reg <= launch && cmd_known && !cmd_viol;
      if (launch) begin
        array_cmd_reg <= i_cmd;
      end
    end
  end
  assign o_array_go = array_go_reg;
  assign o_array_cmd = array_cmd_reg;

  // Read data one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else if (i_reg_rd) begin
      rdata_reg <= 8'h00;
      case (i_reg_addr)
        fepi_pkg::REG_FLASH_STATUS: begin
          rdata_reg[fepi_pkg::ST_CMD_COMPLETE_BIT] <= cmd_complete_flag;
          rdata_reg[fepi_pkg::ST_PROT_VIOL_BIT] <= protection_violation_flag;
        end
        fepi_pkg::REG_FLASH_CONFIG: begin
          rdata_reg[fepi_pkg::CFG_CMD_IRQ_EN_BIT] <= cmd_complete_irq_en;
        end
        fepi_pkg::REG_ERROR_STATUS: begin
          rdata_reg[fepi_pkg::ERR_DOUBLE_BIT] <= ecc_double_fault_flag;
          rdata_reg[fepi_pkg::ERR_SINGLE_BIT] <= ecc_single_fault_flag;
        end
        fepi_pkg::REG_ERROR_CONFIG: begin
          rdata_reg[fepi_pkg::ERR_DOUBLE_BIT] <= ecc_double_fault_irq_en;
          rdata_reg[fepi_pkg::ERR_SINGLE_BIT] <= ecc_single_fault_irq_en;
        end
        fepi_pkg::REG_FLASH_PROTECT: rdata_reg <= flash_protect_reg;
        fepi_pkg::REG_EEPROM_PROTECT: rdata_reg <= eeprom_protect_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end
  assign o_reg_rdata = rdata_reg;

  // Interrupt levels, held until flag or enable clears, gated by mask.
  assign o_cmd_irq = cmd_complete_flag && cmd_complete_irq_en &&
                     !i_irq_mask;
  assign o_err_irq = ((ecc_double_fault_flag && ecc_double_fault_irq_en) ||
                      (ecc_single_fault_flag && ecc_single_fault_irq_en)) &&
                     !i_irq_mask;

  // Checks on the behaviour above.
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_cmd_irq_rise: assert property (
    $rose(cmd_complete_flag) && cmd_complete_irq_en && !i_irq_mask
    |-> o_cmd_irq)
    else $error("Command interrupt missing after completion.");
  a_err_irq_double: assert property (
    $past(i_ecc_double) && ecc_double_fault_irq_en && !i_irq_mask
    |-> o_err_irq)
    else $error("Error interrupt missing after double fault.");
  a_irq_masked_out: assert property (
    i_irq_mask |-> !o_cmd_irq && !o_err_irq)
    else $error("Interrupt raised while globally masked.");
  a_flash_protect_reg_load_value: assert property (
    state_reg == fepi_pkg::FEPI_LOAD_LAST
    |=> flash_protect_reg == ($past(i_cfg_data) & fepi_pkg::FP_MASK))
    else $error("Flash protection not loaded from configuration.");
  a_eeprom_protect_reg_load_value: assert property (
    state_reg == fepi_pkg::FEPI_LOAD_FL
    |=> eeprom_protect_reg == ($past(i_cfg_data) & fepi_pkg::EE_MASK))
    else $error("EEPROM protection not loaded from configuration.");
  a_flash_protect_reg_bad_write: assert property (
    fp_wr && !fepi_pkg::SCEN_ALLOWED[scen_now][scen_new]
    |=> $stable(flash_protect_reg))
    else $error("Disallowed protection write changed the register.");
  a_scen_full_lock: assert property (
    loaded && scen_now == 3'h3 |=> scen_now == 3'h3)
    else $error("Full protection scenario was left.");
  a_flash_protect_reg_readback: assert property (
    i_reg_rd && i_reg_addr == fepi_pkg::REG_FLASH_PROTECT
    |=> o_reg_rdata == $past(flash_protect_reg))
    else $error("Protection read does not show active scenario.");
  a_cmd_done_flag: assert property (
    state_reg == fepi_pkg::FEPI_BUSY && i_array_done
    |=> !cmd_complete_flag ##1 cmd_complete_flag)
    else $error("Complete flag not set after array finished.");
  a_viol_blocks_go: assert property (
    launch && cmd_viol |=> protection_violation_flag && !o_array_go)
    else $error("Protected command reached the array.");

endmodule

// ===== hw/fepi_range_check.sv
// Inclusive address range comparator used for the higher, lower and EEPROM regions.
`timescale 1ns/100ps
module fepi_range_check #(
  parameter int WIDTH = 24
) (
  input wire logic [WIDTH-1:0] i_addr,
  input wire logic [WIDTH-1:0] i_first,
  input wire logic [WIDTH-1:0] i_last,
  output logic o_hit
);

  // The address hits when it lies between both bounds, bounds included.
  assign o_hit = (i_addr >= i_first) && (i_addr <= i_last);

endmodule
